// File: hdl/gptb_top.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "gptb_params.svh"

module gptb_top #(
  parameter int NB = `GPTB_NUM_BLOCKS,
  parameter int W  = `GPTB_HALF_W,
  parameter int PW = `GPTB_PRE_W
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic [`GPTB_ADDR_W-1:0]   i_addr,
  input  wire logic [`GPTB_DATA_W-1:0]   i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [`GPTB_DATA_W-1:0]   o_rdata,
  input  wire logic [2*NB-1:0]           i_ccp_in,
  output logic      [2*NB-1:0]           o_ccp_out,
  output logic      [2*NB-1:0]           o_ccp_oe_n,
  output logic      [NB-1:0]             o_adc_trig,
  output logic                           o_irq
);
  import gptb_pkg::*;

  localparam int EW = NB * `GPTB_EVT_PER_BLK;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared signals.

  logic                      glob_sel;
  logic [1:0]                blk_sel;
  logic [4:0]                off_sel;
  logic [`GPTB_DATA_W-1:0]   blk_rdata [NB];
  logic [EW-1:0]             evt_all;
  logic [EW-1:0]             status_reg;
  logic [EW-1:0]             status_next;
  logic [EW-1:0]             mask_reg;
  logic [`GPTB_DATA_W-1:0]   rdata_reg;
  logic [`GPTB_DATA_W-1:0]   rdata_next;
  logic                      irq_reg;
  logic [2*NB-1:0]           pwm_out;

  assign glob_sel = i_addr[`GPTB_ADDR_GLOBAL];
  assign blk_sel  = i_addr[`GPTB_ADDR_BLK_HI:`GPTB_ADDR_BLK_LO];
  assign off_sel  = i_addr[`GPTB_ADDR_OFF_HI:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Timer blocks.

  for (genvar g = 0; g < NB; g++) begin : g_blk
    logic [`GPTB_CFG_W-1:0]  cfg_reg;
    logic [1:0]              en_reg;
    logic [`GPTB_DATA_W-1:0] load_a_reg;
    logic [`GPTB_DATA_W-1:0] load_b_reg;
    logic [`GPTB_DATA_W-1:0] match_reg;
    logic                    hit_reg;
    logic                    adc_reg;
    logic [1:0]              oe_n_reg;
    logic                    wr_blk;
    logic                    join32;
    logic                    rtc;
    gptb_mode_type           mode_a;
    gptb_mode_type           mode_b;
    gptb_mode_type           mode_a_eff;
    gptb_mode_type           mode_b_eff;
    logic                    evt_a;
    logic                    evt_b;
    logic                    tick_a;
    logic                    tick_b;
    logic                    rl_a;
    logic                    rl_b;
    logic                    rl_a_eff;
    logic                    rl_b_eff;
    logic                    wrap_a;
    logic                    wrap_b;
    logic                    to_a;
    logic                    to_b;
    logic                    oneshot_a;
    logic                    hit_now;
    logic [W-1:0]            load_a_eff;
    logic [W-1:0]            cnt_a;
    logic [W-1:0]            cnt_b;
    logic [W-1:0]            cap_a;
    logic [W-1:0]            cap_b;
    logic                    cap_evt_a;
    logic                    cap_evt_b;

    assign wr_blk = i_wr & ~glob_sel & (blk_sel == 2'(g));
    assign join32 = cfg_reg[`GPTB_CFG_JOIN];
    assign rtc    = cfg_reg[`GPTB_CFG_RTC];
    assign mode_a = gptb_mode_type'(cfg_reg[`GPTB_CFG_MODE_A_HI:`GPTB_CFG_MODE_A_LO]);
    assign mode_b = gptb_mode_type'(cfg_reg[`GPTB_CFG_MODE_B_HI:`GPTB_CFG_MODE_B_LO]);

    // Joined halves always cascade freely; one-shot stopping is done here by the enable.
    assign mode_a_eff = join32 ? GPTB_PERIODIC : mode_a;
    assign mode_b_eff = join32 ? GPTB_PERIODIC : mode_b;
    assign oneshot_a  = join32 ? (~rtc & (mode_a == GPTB_ONESHOT)) : (mode_a == GPTB_ONESHOT);

    // A write that turns a half on, or any load write, restarts it from the load register as it stood before that write.
    assign rl_a = (wr_blk & (off_sel == `GPTB_OFF_CTRL) & i_wdata[`GPTB_CTRL_EN_A] & ~en_reg[0])
                | (wr_blk & (off_sel == `GPTB_OFF_LOAD_A));
    assign rl_b = (wr_blk & (off_sel == `GPTB_OFF_CTRL) & i_wdata[`GPTB_CTRL_EN_B] & ~en_reg[1])
                | (wr_blk & (off_sel == `GPTB_OFF_LOAD_B));
    assign rl_a_eff = join32 ? (rl_a | rl_b) : rl_a;
    assign rl_b_eff = join32 ? (rl_a | rl_b) : rl_b;

    // Joined, the low half must pass through all ones while the high half still has
    // counts left, otherwise the pair would act as two chained short periods.
    assign load_a_eff = (join32 & ~rl_a_eff & (cnt_b != '0)) ? '1
                      : load_a_reg[`GPTB_LOAD_CNT_HI:0];

    gptb_edge u_edge_a (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_pin     (i_ccp_in[2*g]),
      .i_sel     (gptb_edge_type'(cfg_reg[`GPTB_CFG_EDGE_A_HI:`GPTB_CFG_EDGE_A_LO])),
      .o_evt     (evt_a)
    );

    gptb_edge u_edge_b (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_pin     (i_ccp_in[2*g+1]),
      .i_sel     (gptb_edge_type'(cfg_reg[`GPTB_CFG_EDGE_B_HI:`GPTB_CFG_EDGE_B_LO])),
      .o_evt     (evt_b)
    );

    assign tick_a = cfg_reg[`GPTB_CFG_EXT_A] ? evt_a : 1'b1;
    assign tick_b = cfg_reg[`GPTB_CFG_EXT_B] ? evt_b : 1'b1;

    gptb_half #(.W(W), .PW(PW)) u_half_a (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_run      (en_reg[0]),
      .i_mode     (mode_a_eff),
      .i_up       (join32 & rtc),
      .i_use_pre  (~join32 & cfg_reg[`GPTB_CFG_PRE_A]),
      .i_tick     (tick_a),
      .i_reload   (rl_a_eff),
      .i_cap      (evt_a),
      .i_inv      (cfg_reg[`GPTB_CFG_INV_A]),
      .i_pre_load (load_a_reg[`GPTB_LOAD_PRE_HI:`GPTB_LOAD_PRE_LO]),
      .i_load     (load_a_eff),
      .i_match    (match_reg[W-1:0]),
      .o_wrap     (wrap_a),
      .o_count    (cnt_a),
      .o_capture  (cap_a),
      .o_cap_evt  (cap_evt_a),
      .o_pwm      (pwm_out[2*g])
    );

    // In joined mode the upper half steps once per wrap of the lower half.
    gptb_half #(.W(W), .PW(PW)) u_half_b (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_run      (join32 ? en_reg[0] : en_reg[1]),
      .i_mode     (mode_b_eff),
      .i_up       (join32 & rtc),
      .i_use_pre  (~join32 & cfg_reg[`GPTB_CFG_PRE_B]),
      .i_tick     (join32 ? wrap_a : tick_b),
      .i_reload   (rl_b_eff),
      .i_cap      (~join32 & evt_b),
      .i_inv      (cfg_reg[`GPTB_CFG_INV_B]),
      .i_pre_load (load_b_reg[`GPTB_LOAD_PRE_HI:`GPTB_LOAD_PRE_LO]),
      .i_load     (load_b_reg[`GPTB_LOAD_CNT_HI:0]),
      .i_match    (match_reg[2*W-1:W]),
      .o_wrap     (wrap_b),
      .o_count    (cnt_b),
      .o_capture  (cap_b),
      .o_cap_evt  (cap_evt_b),
      .o_pwm      (pwm_out[2*g+1])
    );

    assign to_a    = join32 ? (wrap_b & ~rtc) : wrap_a;
    assign to_b    = ~join32 & wrap_b;
    assign hit_now = join32 & rtc & en_reg[0] & ({cnt_b, cnt_a} == match_reg);

    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        cfg_reg    <= `GPTB_CFG_W'(`GPTB_RST_WORD);
        load_a_reg <= `GPTB_RST_WORD;
        load_b_reg <= `GPTB_RST_WORD;
        match_reg  <= `GPTB_RST_WORD;
      end else if (wr_blk) begin
        case (off_sel)
          `GPTB_OFF_CFG:    cfg_reg    <= i_wdata[`GPTB_CFG_W-1:0];
          `GPTB_OFF_LOAD_A: load_a_reg <= i_wdata;
          `GPTB_OFF_LOAD_B: load_b_reg <= i_wdata;
          `GPTB_OFF_MATCH:  match_reg  <= i_wdata;
          default:          ;
        endcase
      end
    end

    // A software write to the enables takes precedence over the one-shot stop.
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        en_reg <= 2'b00;
      end else if (wr_blk && off_sel == `GPTB_OFF_CTRL) begin
        en_reg <= i_wdata[`GPTB_CTRL_EN_B:`GPTB_CTRL_EN_A];
      end else begin
        if (to_a && oneshot_a) begin
          en_reg[0] <= 1'b0;
        end
        if (to_b && mode_b == GPTB_ONESHOT) begin
          en_reg[1] <= 1'b0;
        end
      end
    end

    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        hit_reg  <= 1'b0;
        adc_reg  <= 1'b0;
        oe_n_reg <= 2'b11;
      end else begin
        hit_reg  <= hit_now;
        adc_reg  <= (to_a & cfg_reg[`GPTB_CFG_ADC_A]) | (to_b & cfg_reg[`GPTB_CFG_ADC_B]);
        oe_n_reg <= {~(~join32 & (mode_b == GPTB_PWM)), ~(~join32 & (mode_a == GPTB_PWM))};
      end
    end

    assign o_adc_trig[g]          = adc_reg;
    assign o_ccp_oe_n[2*g+1:2*g]  = oe_n_reg;
    assign evt_all[`GPTB_EVT_PER_BLK*g +: `GPTB_EVT_PER_BLK] =
      {cap_evt_b, cap_evt_a | (hit_now & ~hit_reg), to_b, to_a};

    always_comb begin
      case (off_sel)
        `GPTB_OFF_CFG:    blk_rdata[g] = `GPTB_DATA_W'(cfg_reg);
        `GPTB_OFF_CTRL:   blk_rdata[g] = `GPTB_DATA_W'(en_reg);
        `GPTB_OFF_LOAD_A: blk_rdata[g] = load_a_reg;
        `GPTB_OFF_LOAD_B: blk_rdata[g] = load_b_reg;
        `GPTB_OFF_MATCH:  blk_rdata[g] = match_reg;
        `GPTB_OFF_COUNT:  blk_rdata[g] = {cnt_b, cnt_a};
        `GPTB_OFF_CAPT:   blk_rdata[g] = {cap_b, cap_a};
        default:          blk_rdata[g] = `GPTB_RST_WORD;
      endcase
    end
  end

  assign o_ccp_out = pwm_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  // A new event beats a write-one-to-clear in the same cycle.
  always_comb begin
    status_next = status_reg;
    if (i_wr && i_addr == `GPTB_ADDR_STATUS) begin
      status_next = status_next & ~i_wdata[EW-1:0];
    end
    status_next = status_next | evt_all;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      status_reg <= `GPTB_RST_EVT;
    end else begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mask_reg <= `GPTB_RST_EVT;
    end else if (i_wr && i_addr == `GPTB_ADDR_MASK) begin
      mask_reg <= i_wdata[EW-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign o_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Read port.

  always_comb begin
    if (!glob_sel) begin
      rdata_next = blk_rdata[blk_sel];
    end else if (i_addr == `GPTB_ADDR_STATUS) begin
      rdata_next = `GPTB_DATA_W'(status_reg);
    end else if (i_addr == `GPTB_ADDR_MASK) begin
      rdata_next = `GPTB_DATA_W'(mask_reg);
    end else begin
      rdata_next = `GPTB_RST_WORD;
    end
  end

  // Read data is zero outside the answer cycle, which keeps a stale word off the bus.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_reg <= `GPTB_RST_WORD;
    end else begin
      rdata_reg <= i_rd ? rdata_next : `GPTB_RST_WORD;
    end
  end

  assign o_rdata = rdata_reg;

endmodule : gptb_top

// File: hdl/gptb_params.svh
`ifndef GPTB_PARAMS_SVH
`define GPTB_PARAMS_SVH

// Structure.
`define GPTB_NUM_BLOCKS    4
`define GPTB_HALF_W        16
`define GPTB_PRE_W         8
`define GPTB_ADDR_W        8
`define GPTB_DATA_W        32
`define GPTB_EVT_PER_BLK   4

// Address map: bit 7 selects the global page, bits 6:5 the block, 4:0 the offset.
`define GPTB_ADDR_GLOBAL   7
`define GPTB_ADDR_BLK_HI   6
`define GPTB_ADDR_BLK_LO   5
`define GPTB_ADDR_OFF_HI   4
`define GPTB_OFF_CFG       5'h00
`define GPTB_OFF_CTRL      5'h04
`define GPTB_OFF_LOAD_A    5'h08
`define GPTB_OFF_LOAD_B    5'h0c
`define GPTB_OFF_MATCH     5'h10
`define GPTB_OFF_COUNT     5'h14
`define GPTB_OFF_CAPT      5'h18
`define GPTB_ADDR_STATUS   8'h80
`define GPTB_ADDR_MASK     8'h84

// Configuration word fields.
`define GPTB_CFG_JOIN      0
`define GPTB_CFG_RTC       1
`define GPTB_CFG_MODE_A_LO 2
`define GPTB_CFG_MODE_A_HI 3
`define GPTB_CFG_MODE_B_LO 4
`define GPTB_CFG_MODE_B_HI 5
`define GPTB_CFG_PRE_A     6
`define GPTB_CFG_PRE_B     7
`define GPTB_CFG_EXT_A     8
`define GPTB_CFG_EXT_B     9
`define GPTB_CFG_EDGE_A_LO 10
`define GPTB_CFG_EDGE_A_HI 11
`define GPTB_CFG_EDGE_B_LO 12
`define GPTB_CFG_EDGE_B_HI 13
`define GPTB_CFG_INV_A     14
`define GPTB_CFG_INV_B     15
`define GPTB_CFG_ADC_A     16
`define GPTB_CFG_ADC_B     17
`define GPTB_CFG_W         18

// Control word fields.
`define GPTB_CTRL_EN_A     0
`define GPTB_CTRL_EN_B     1

// Load word fields.
`define GPTB_LOAD_CNT_HI   15
`define GPTB_LOAD_PRE_LO   16
`define GPTB_LOAD_PRE_HI   23

// Event bits inside a block's nibble.
`define GPTB_EVT_TO_A      0
`define GPTB_EVT_TO_B      1
`define GPTB_EVT_CAP_A     2
`define GPTB_EVT_CAP_B     3

// Reset values.
`define GPTB_RST_WORD      32'h0000_0000
`define GPTB_RST_EVT       16'h0000

`endif

// File: hdl/gptb_pkg.sv
package gptb_pkg;

  typedef enum logic [1:0] {
    GPTB_ONESHOT  = 2'b00,
    GPTB_PERIODIC = 2'b01,
    GPTB_CAPTURE  = 2'b10,
    GPTB_PWM      = 2'b11
  } gptb_mode_type;

  typedef enum logic [1:0] {
    GPTB_EDGE_RISE = 2'b00,
    GPTB_EDGE_FALL = 2'b01,
    GPTB_EDGE_BOTH = 2'b10,
    GPTB_EDGE_NONE = 2'b11
  } gptb_edge_type;

endpackage : gptb_pkg

// File: hdl/gptb_edge.sv
`timescale 1ns/1ps
`include "gptb_params.svh"

module gptb_edge (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_pin,
  input  gptb_pkg::gptb_edge_type    i_sel,
  output logic                       o_evt
);
  import gptb_pkg::*;

  logic prev_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= i_pin;
    end
  end

  always_comb begin
    case (i_sel)
      GPTB_EDGE_RISE: o_evt = i_pin & ~prev_reg;
      GPTB_EDGE_FALL: o_evt = ~i_pin & prev_reg;
      GPTB_EDGE_BOTH: o_evt = i_pin ^ prev_reg;
      default:        o_evt = 1'b0;
    endcase
  end

endmodule : gptb_edge

// File: hdl/gptb_half.sv
`timescale 1ns/1ps
`include "gptb_params.svh"

module gptb_half #(
  parameter int W  = `GPTB_HALF_W,
  parameter int PW = `GPTB_PRE_W
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_run,
  input  gptb_pkg::gptb_mode_type    i_mode,
  input  wire logic                  i_up,
  input  wire logic                  i_use_pre,
  input  wire logic                  i_tick,
  input  wire logic                  i_reload,
  input  wire logic                  i_cap,
  input  wire logic                  i_inv,
  input  wire logic [PW-1:0]         i_pre_load,
  input  wire logic [W-1:0]          i_load,
  input  wire logic [W-1:0]          i_match,
  output logic                       o_wrap,
  output logic [W-1:0]               o_count,
  output logic [W-1:0]               o_capture,
  output logic                       o_cap_evt,
  output logic                       o_pwm
);
  import gptb_pkg::*;

  logic [PW-1:0] pre_reg;
  logic [W-1:0]  count_reg;
  logic [W-1:0]  capture_reg;
  logic          cap_evt_reg;
  logic          pwm_reg;
  logic          step;
  logic          at_end;

  // The prescaler only lets every (pre_load+1)-th tick through to the counter.
  assign step    = i_run & i_tick & (~i_use_pre | (pre_reg == '0));
  assign at_end  = i_up ? (count_reg == '1) : (count_reg == '0);
  assign o_wrap  = step & at_end;
  assign o_count = count_reg;
  assign o_capture = capture_reg;
  assign o_cap_evt = cap_evt_reg;
  assign o_pwm     = pwm_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pre_reg <= '0;
    end else if (i_reload) begin
      pre_reg <= i_pre_load;
    end else if (i_run & i_tick & i_use_pre) begin
      pre_reg <= (pre_reg == '0) ? i_pre_load : pre_reg - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_reg <= '0;
    end else if (i_reload) begin
      count_reg <= i_load;
    end else if (step) begin
      if (i_up) begin
        count_reg <= count_reg + 1'b1;
      end else if (at_end && i_mode == GPTB_ONESHOT) begin
        count_reg <= count_reg;
      end else if (at_end) begin
        count_reg <= i_load;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      capture_reg <= '0;
      cap_evt_reg <= 1'b0;
    end else begin
      cap_evt_reg <= i_cap & i_run & (i_mode == GPTB_CAPTURE);
      if (i_cap && i_run && i_mode == GPTB_CAPTURE) begin
        capture_reg <= count_reg;
      end
    end
  end

  // Outside PWM the pin is released, so the inversion is not applied there.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= (i_mode == GPTB_PWM) & ((count_reg > i_match) ^ i_inv);
    end
  end

endmodule : gptb_half

// File: test/gptb_properties.sv
`timescale 1ns/1ps
`include "gptb_params.svh"

module gptb_chk #(
  parameter int NB = `GPTB_NUM_BLOCKS
) (
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst,
  input wire logic [`GPTB_ADDR_W-1:0] i_addr,
  input wire logic [`GPTB_DATA_W-1:0] i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [`GPTB_DATA_W-1:0] o_rdata,
  input wire logic [2*NB-1:0]         i_ccp_in,
  input wire logic [2*NB-1:0]         o_ccp_out,
  input wire logic [2*NB-1:0]         o_ccp_oe_n,
  input wire logic [NB-1:0]           o_adc_trig,
  input wire logic                    o_irq
);
  logic       blk;
  logic [4:0] off;

  assign blk = !i_addr[`GPTB_ADDR_GLOBAL];
  assign off = i_addr[`GPTB_ADDR_OFF_HI:0];

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////
  property p_rdata_idle;
    !i_rd |=> o_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_gap_zero;
    i_rd && ((blk && off == 5'h1c) || (!blk && i_addr != `GPTB_ADDR_STATUS
      && i_addr != `GPTB_ADDR_MASK)) |=> o_rdata == '0;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("unmapped read not zero");
  property p_event_hi_zero;
    i_rd && (i_addr == `GPTB_ADDR_STATUS || i_addr == `GPTB_ADDR_MASK)
      |=> o_rdata[31:16] == 16'h0000;
  endproperty
  a_event_hi_zero: assert property (p_event_hi_zero) else $error("event word too wide");
  property p_cfg_hi_zero;
    i_rd && blk && off == `GPTB_OFF_CFG |=> o_rdata[31:`GPTB_CFG_W] == '0;
  endproperty
  a_cfg_hi_zero: assert property (p_cfg_hi_zero) else $error("config word too wide");
  property p_reset_idle;
    $fell(i_rst) |-> o_rdata == '0 && !o_irq && o_adc_trig == '0 && (&o_ccp_oe_n)
      && o_ccp_out == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_mask_off_irq;
    i_wr && i_addr == `GPTB_ADDR_MASK && i_wdata[15:0] == 16'h0000 |-> ##2 !o_irq;
  endproperty
  a_mask_off_irq: assert property (p_mask_off_irq) else $error("irq with all masked");
  property p_load_readback;
    (i_wr && blk && off == `GPTB_OFF_LOAD_A) ##1 (i_rd && $stable(i_addr))
      |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_load_readback: assert property (p_load_readback) else $error("load readback wrong");
  property p_pin_idle;
    1'b1 |-> (o_ccp_out & o_ccp_oe_n & $past(o_ccp_oe_n)) == '0;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("undriven pin shows level");
endmodule : gptb_chk

bind gptb_top gptb_chk #(.NB(NB)) i_chk (
  .i_sys_clk  (i_sys_clk),
  .i_rst      (i_rst),
  .i_addr     (i_addr),
  .i_wdata    (i_wdata),
  .i_wr       (i_wr),
  .i_rd       (i_rd),
  .o_rdata    (o_rdata),
  .i_ccp_in   (i_ccp_in),
  .o_ccp_out  (o_ccp_out),
  .o_ccp_oe_n (o_ccp_oe_n),
  .o_adc_trig (o_adc_trig),
  .o_irq      (o_irq)
);

// File: test/gptb_pin_model.sv
`timescale 1ns/1ps

module gptb_pin_model #(
  parameter int N = 8
) (
  input  wire logic         i_sys_clk,
  input  wire logic [N-1:0] i_flip,
  input  wire logic [N-1:0] i_out,
  input  wire logic [N-1:0] i_oe_n,
  output logic      [N-1:0] o_pin
);
  logic [N-1:0] lvl_reg = '0;

  always @(posedge i_sys_clk) begin
    lvl_reg <= lvl_reg ^ i_flip;
  end
  // The wire follows the timer wherever it drives, so the source never fights it.
  assign o_pin = (i_oe_n & lvl_reg) | (~i_oe_n & i_out);
endmodule : gptb_pin_model

// File: test/tb.sv
`timescale 1ns/1ps
`include "gptb_params.svh"

`define TB_CHK(g, e) \
  begin \
    total_checks++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end

module tb;
  logic        i_sys_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic [7:0]  pin_wire;
  logic [7:0]  pwm_out;
  logic [7:0]  pwm_oe_n;
  logic [7:0]  flip = 8'h00;
  logic [3:0]  o_adc_trig;
  logic        o_irq;
  logic [31:0] rnd = 32'd84;
  logic [31:0] d;
  int          error_cnt = 0;
  int          total_checks = 0;

  always #25 i_sys_clk = ~i_sys_clk;

  gptb_top i_dut (
    .i_sys_clk  (i_sys_clk),
    .i_rst      (i_rst),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .i_ccp_in   (pin_wire),
    .o_ccp_out  (pwm_out),
    .o_ccp_oe_n (pwm_oe_n),
    .o_adc_trig (o_adc_trig),
    .o_irq      (o_irq)
  );
  gptb_pin_model i_pins (
    .i_sys_clk (i_sys_clk),
    .i_flip    (flip),
    .i_out     (pwm_out),
    .i_oe_n    (pwm_oe_n),
    .o_pin     (pin_wire)
  );

  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  function automatic logic [7:0] ra(int b, logic [4:0] o);
    return {1'b0, 2'(b), o};
  endfunction : ra
  task automatic tick(int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask : tick
  task automatic cyc(logic w, logic r, logic [7:0] a, logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr    <= w;
    i_rd    <= r;
    i_addr  <= a;
    i_wdata <= v;
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [31:0] v);
    cyc(1'b1, 1'b0, a, v);
    cyc(1'b0, 1'b0, a, v);
  endtask : wr
  task automatic rd(logic [7:0] a);
    cyc(1'b0, 1'b1, a, 32'h0);
    cyc(1'b0, 1'b0, a, 32'h0);
    #1;
    d = o_rdata;
  endtask : rd
  task automatic reset_check();
    for (int a = 0; a <= 8'h84; a += 4) begin
      rd(a[7:0]);
      `TB_CHK(d, 32'h0)
    end
  endtask : reset_check
  // Bounded wait; returns the number of cycles until the block's trigger pulse.
  task automatic wait_adc(int b, output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (o_adc_trig[b] !== 1'b1 && n < 3000);
  endtask : wait_adc
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////
  initial begin
    #(50 * 30000);
    error_cnt++;
    test_done();
  end

  initial begin
    int n, b, l, p, e, o;
    logic [31:0] v;
    repeat (8) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    reset_check();
    // Enables stay off here, so counters cannot disturb what is read back.
    for (b = 0; b < 4; b++) begin
      for (o = 0; o < 32; o += 4) begin
        v = (o == 4) ? 32'h0 : xs() & ~32'h1;
        cyc(1'b1, 1'b0, ra(b, o[4:0]), v);
        rd(ra(b, o[4:0]));
        if (o != 20) `TB_CHK(d, (o == 0) ? v & 32'h3ffff : (o >= 8 && o <= 16) ? v : 32'h0)
      end
      wr(ra(b, `GPTB_OFF_CFG), 32'h0);
    end
    b = int'(xs() % 32'd4);
    l = int'(xs() % 32'd8);
    p = int'(xs() % 32'd4);
    wr(ra(b, `GPTB_OFF_LOAD_A), {8'h00, p[7:0], l[15:0]});
    wr(ra(b, `GPTB_OFF_CFG), 32'h0001_0044);
    wr(`GPTB_ADDR_MASK, 32'h1 << (4 * b));
    wr(ra(b, `GPTB_OFF_CTRL), 32'h1);
    wait_adc(b, n);
    wait_adc(b, n);
    `TB_CHK(n, (l + 1) * (p + 1))
    wr(ra(b, `GPTB_OFF_CTRL), 32'h0);
    `TB_CHK(o_irq, 1'b1)
    rd(`GPTB_ADDR_STATUS);
    `TB_CHK(d, 32'h1 << (4 * b))
    wr(`GPTB_ADDR_MASK, 32'h0);
    tick(1);
    `TB_CHK(o_irq, 1'b0)
    wr(`GPTB_ADDR_STATUS, 32'hffff);
    rd(`GPTB_ADDR_STATUS);
    `TB_CHK(d, 32'h0)
    b = (b + 1) % 4;
    wr(ra(b, `GPTB_OFF_LOAD_B), {16'h0, l[15:0]});
    wr(ra(b, `GPTB_OFF_CFG), 32'h0002_0000);
    wr(ra(b, `GPTB_OFF_CTRL), 32'h2);
    wait_adc(b, n);
    `TB_CHK(n, l + 1)
    n = 0;
    repeat (3 * l + 6) begin
      tick(1);
      n += int'(o_adc_trig[b]);
    end
    `TB_CHK(n, 0)
    rd(ra(b, `GPTB_OFF_CTRL));
    `TB_CHK(d, 32'h0)
    rd(ra(b, `GPTB_OFF_COUNT));
    `TB_CHK(d[31:16], 16'h0)
    for (e = 0; e < 4; e++) begin
      wr(ra(2, `GPTB_OFF_CFG), 32'h104 | (e << 10));
      wr(ra(2, `GPTB_OFF_LOAD_A), 32'd9);
      wr(ra(2, `GPTB_OFF_CTRL), 32'h1);
      repeat (6) begin
        @(posedge i_sys_clk) flip <= 8'h10;
        @(posedge i_sys_clk) flip <= 8'h00;
      end
      tick(4);
      rd(ra(2, `GPTB_OFF_COUNT));
      `TB_CHK(d[15:0], 16'(9 - ((e == 2) ? 6 : (e == 3) ? 0 : 3)))
      wr(ra(2, `GPTB_OFF_CTRL), 32'h0);
    end
    for (e = 0; e < 2; e++) begin
      wr(ra(0, `GPTB_OFF_CFG), 32'h30 | (e << 15));
      wr(ra(0, `GPTB_OFF_LOAD_B), 32'd9);
      wr(ra(0, `GPTB_OFF_MATCH), 32'h0002_0000);
      wr(ra(0, `GPTB_OFF_CTRL), 32'h2);
      tick(3);
      n = 0;
      repeat (10) begin
        tick(1);
        n += int'(pin_wire[1]);
      end
      `TB_CHK(n, (e == 1) ? 3 : 7)
      `TB_CHK(pwm_oe_n[1], 1'b0)
      wr(ra(0, `GPTB_OFF_CTRL), 32'h0);
      wr(ra(0, `GPTB_OFF_CFG), 32'h0);
    end
    wr(ra(1, `GPTB_OFF_LOAD_A), 32'h100);
    wr(ra(1, `GPTB_OFF_CFG), 32'h8);
    wr(ra(1, `GPTB_OFF_CTRL), 32'h1);
    @(posedge i_sys_clk) flip <= 8'h04;
    @(posedge i_sys_clk) flip <= 8'h00;
    tick(4);
    rd(ra(1, `GPTB_OFF_CAPT));
    `TB_CHK(d[15:0], 16'h00fe)
    rd(`GPTB_ADDR_STATUS);
    `TB_CHK(d[6], 1'b1)
    wr(ra(1, `GPTB_OFF_CTRL), 32'h0);
    wr(ra(3, `GPTB_OFF_LOAD_A), 32'd3);
    wr(ra(3, `GPTB_OFF_LOAD_B), 32'd1);
    wr(ra(3, `GPTB_OFF_CFG), 32'h5);
    wr(ra(3, `GPTB_OFF_CTRL), 32'h1);
    tick(10);
    rd(ra(3, `GPTB_OFF_COUNT));
    `TB_CHK(d[31:16], 16'h0)
    `TB_CHK(d[15:0], 16'hfff8)
    wr(ra(3, `GPTB_OFF_CTRL), 32'h0);
    wr(`GPTB_ADDR_STATUS, 32'hffff);
    wr(ra(3, `GPTB_OFF_LOAD_A), 32'h0);
    wr(ra(3, `GPTB_OFF_LOAD_B), 32'h0);
    wr(ra(3, `GPTB_OFF_MATCH), 32'd30);
    wr(ra(3, `GPTB_OFF_CFG), 32'h3);
    wr(`GPTB_ADDR_MASK, 32'h4000);
    wr(ra(3, `GPTB_OFF_CTRL), 32'h1);
    n = 0;
    while (o_irq !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    rd(`GPTB_ADDR_STATUS);
    `TB_CHK(d, 32'h4000)
    @(posedge i_sys_clk) i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    reset_check();
    test_done();
  end
endmodule : tb
